// File: nci_host.sv
// Host engine that drives a parallel NAND flash through its pins
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module nci_host
    import nci_pkg::*;
#(
    parameter int          TMR_W     = 20,
    parameter int          PROG_CYC  = nci_pkg::PAGE_WRITE_CYC,
    parameter int          PROGR_CYC = nci_pkg::PAGE_WRITE_R_CYC,
    parameter int          CACHE_CYC = nci_pkg::CACHE_WRITE_CYC,
    parameter int          ERASE_CYC = nci_pkg::BLOCK_CLEAR_CYC,
    parameter int          ERS2_CYC  = nci_pkg::BLOCK_CLEAR2_CYC,
    parameter int          RST_CYC   = nci_pkg::RESET_CYC,
    parameter logic [23:0] PAGE_MASK = 24'h00003f
) (
    input  wire logic              clk,     // 100 MHz clock
    input  wire logic              sys_rst, // Async reset, high
    input  wire nci_pkg::nci_req_s req,     // Register request
    output logic [31:0]            rdata,   // Read data, next cycle
    output nci_pkg::nci_pins_s     pins,    // Flash control pins
    output logic [7:0]             dq_o,    // Data bus out
    output logic                   dq_oe,   // Data bus drive enable
    input  wire logic [7:0]        dq_i,    // Data bus in
    input  wire logic              rb_n     // Ready, low when busy
);
    import nci_pkg::*;

    generate
        if (TMR_W < $clog2(ERS2_CYC + 1) || TMR_W > 31) begin : g_chk
            $error("nci_host: TMR_W cannot hold the longest limit");
        end
    endgenerate

    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_WLOW, S_WHIGH, S_RGAP, S_RLOW, S_RHIGH,
        S_BGAP, S_BUSY
    } nci_state_e;

    nci_state_e              state_q, state_d;
    nci_kind_e               kind_q, kind_d;
    logic [7:0]              byte_q, byte_d, rbyte_q, rbyte_d;
    logic [TMR_W-1:0]        lim_q, lim_d, tmr_val;
    logic                    post_q, post_d, tmr_load, tmr_done;
    logic [CTRL_W-1:0]       ctrl_q, ctrl_d;
    logic                    tmo_q, tmo_d, ref_q, ref_d;
    logic                    tpp_q, tpp_d, tpe_q, tpe_d;
    logic [23:0]             key_q, key_d, lkey_q, lkey_d, pkey_q, pkey_d;
    logic [2:0]              cnt_q, cnt_d, ncnt, limit;
    logic [7:0]              last_q, last_d;
    logic [31:0]             rdata_q, rdata_d;
    nci_pins_s               pins_q, pins_d;
    logic                    wr_op, refuse;
    logic [7:0]              code;

    // Codes the flash defines, one- to four-cycle sets
    function automatic logic valid_cmd(input logic [7:0] c);
        case (c)
            CMD_READ, CMD_READ_CONF, CMD_RND_OUT, CMD_RND_OUT_C,
            CMD_RND_IN, CMD_CACHE_RD, CMD_CACHE_END, CMD_ID, CMD_PARAM,
            CMD_UID, CMD_SET_FEAT, CMD_GET_FEAT, CMD_RESET, CMD_PROG,
            CMD_PROG_P2, CMD_PROG_CONF, CMD_CACHE_PRG, CMD_PLANE_PRG,
            CMD_ERASE, CMD_ERASE_CNF, CMD_PLANE_ERS, CMD_STATUS,
            CMD_STATUS_EN, CMD_PROT_STAT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Codes that belong to program or erase sequences
    function automatic logic guarded(input logic [7:0] c);
        case (c)
            CMD_PROG, CMD_PROG_P2, CMD_RND_IN, CMD_PROG_CONF,
            CMD_CACHE_PRG, CMD_PLANE_PRG, CMD_ERASE, CMD_ERASE_CNF,
            CMD_PLANE_ERS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Longest busy the flash may show after a code; zero means no wait
    function automatic logic [TMR_W-1:0] wait_cyc(input logic [7:0] c,
                                                  input logic scrm,
                                                  input logic two);
        case (c)
            CMD_READ_CONF: return TMR_W'(ARRAY_FETCH_CYC);
            CMD_CACHE_RD, CMD_CACHE_END:
                return TMR_W'(CACHE_FETCH_CYC);
            CMD_PROG_CONF:
                return scrm ? TMR_W'(PROGR_CYC)
                            : TMR_W'(PROG_CYC);
            CMD_CACHE_PRG:
                return scrm ? TMR_W'(PROGR_CYC)
                            : TMR_W'(CACHE_CYC);
            CMD_PLANE_PRG, CMD_PLANE_ERS:
                return TMR_W'(PLANE_SWITCH_CYC);
            CMD_ERASE_CNF:
                return two ? TMR_W'(ERS2_CYC)
                           : TMR_W'(ERASE_CYC);
            CMD_RESET: return TMR_W'(RST_CYC);
            default: return '0;
        endcase
    endfunction

    nci_timer #(.W(TMR_W)) u_tmr (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    assign code  = req.wdata[7:0];
    assign wr_op = req.wr && (req.addr == REG_CMD || req.addr == REG_ADDR
                   || req.addr == REG_DATA || req.addr == REG_READ
                   || req.addr == REG_WAIT);
    assign limit = ctrl_q[CTRL_SCRM] ? PARTIAL_WRITE_LIMIT_SCRM
                                     : PARTIAL_WRITE_LIMIT;
    assign ncnt  = (key_q == lkey_q) ? cnt_q + 3'h1 : 3'h1;

    // Refusal of a byte request that the flash must not see
    always_comb begin
        refuse = 1'b0;
        if (state_q != S_IDLE || !ctrl_q[CTRL_SEL]) begin
            refuse = 1'b1;
        end else if (req.addr == REG_DATA && !ctrl_q[CTRL_GUARD]) begin
            refuse = 1'b1;
        end else if (req.addr == REG_CMD) begin
            if (!valid_cmd(code)) begin
                refuse = 1'b1;
            end else if (!rb_n && code != CMD_RESET && code != CMD_STATUS
                         && code != CMD_STATUS_EN) begin
                refuse = 1'b1;
            end else if (guarded(code) && !ctrl_q[CTRL_GUARD]) begin
                refuse = 1'b1;
            end else if ((code == CMD_PROG_CONF || code == CMD_CACHE_PRG
                          || code == CMD_PLANE_PRG) && ncnt > limit) begin
                refuse = 1'b1;
            end else if ((code == CMD_PROG_CONF || code == CMD_CACHE_PRG)
                         && tpp_q
                         && ((key_q ^ pkey_q) & PAGE_MASK) != '0) begin
                refuse = 1'b1;
            end
        end
    end

    // Sequencer, sequence tracking and register file next values
    always_comb begin
        state_d  = state_q;
        kind_d   = kind_q;
        byte_d   = byte_q;
        rbyte_d  = rbyte_q;
        lim_d    = lim_q;
        post_d   = post_q;
        ctrl_d   = ctrl_q;
        tpp_d    = tpp_q;
        tpe_d    = tpe_q;
        key_d    = key_q;
        lkey_d   = lkey_q;
        pkey_d   = pkey_q;
        cnt_d    = cnt_q;
        last_d   = last_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        tmo_d    = tmo_q;
        ref_d    = ref_q;
        rdata_d  = '0;
        if (req.wr && req.addr == REG_STATUS) begin
            tmo_d = tmo_q & ~req.wdata[ST_TMO];
            ref_d = ref_q & ~req.wdata[ST_REF];
        end
        if (req.wr && req.addr == REG_CTRL) begin
            ctrl_d = req.wdata[CTRL_W-1:0];
        end
        case (state_q)
            S_IDLE: begin
                if (wr_op && !refuse) begin
                    byte_d  = code;
                    post_d  = 1'b0;
                    state_d = S_SETUP;
                    if (req.addr == REG_CMD) begin
                        kind_d = NCI_CYC_CMD;
                        lim_d  = wait_cyc(code, ctrl_q[CTRL_SCRM], tpe_q);
                        post_d = (wait_cyc(code, ctrl_q[CTRL_SCRM], tpe_q)
                                  != '0);
                        last_d = code;
                        if (code == CMD_PLANE_PRG) begin
                            tpp_d  = 1'b1;
                            pkey_d = key_q;
                        end
                        if (code == CMD_PROG_CONF
                            || code == CMD_CACHE_PRG) begin
                            tpp_d = 1'b0;
                        end
                        if (code == CMD_PROG_CONF || code == CMD_CACHE_PRG
                            || code == CMD_PLANE_PRG) begin
                            cnt_d  = ncnt;
                            lkey_d = key_q;
                        end
                        if (code == CMD_PLANE_ERS || (code == CMD_ERASE
                            && last_q == CMD_ERASE)) begin
                            tpe_d = 1'b1;
                        end
                        if (code == CMD_ERASE_CNF) begin
                            tpe_d = 1'b0;
                            cnt_d = 3'h0;
                        end
                    end else if (req.addr == REG_ADDR) begin
                        kind_d = NCI_CYC_ADDR;
                        key_d  = {key_q[15:0], code};
                    end else if (req.addr == REG_DATA) begin
                        kind_d = NCI_CYC_DATA;
                    end else if (req.addr == REG_READ) begin
                        state_d  = S_RGAP;
                        tmr_load = 1'b1;
                        tmr_val  = TMR_W'(WHR_CYC - 1);
                    end else begin
                        lim_d    = TMR_W'(OPTION_ACCESS_CYC);
                        state_d  = S_BGAP;
                        tmr_load = 1'b1;
                        tmr_val  = TMR_W'(WB_CYC - 1);
                    end
                end else if (wr_op) begin
                    ref_d = 1'b1;
                end
            end
            S_SETUP: begin
                state_d  = S_WLOW;
                tmr_load = 1'b1;
                tmr_val  = TMR_W'(WE_LOW_CYC - 1);
            end
            S_WLOW: begin
                if (tmr_done) begin
                    state_d  = S_WHIGH;
                    tmr_load = 1'b1;
                    tmr_val  = TMR_W'(WE_HIGH_CYC - 1);
                end
            end
            S_WHIGH: begin
                if (tmr_done) begin
                    state_d = post_q ? S_BGAP : S_IDLE;
                    tmr_load = post_q;
                    tmr_val  = TMR_W'(WB_CYC - 1);
                end
            end
            S_RGAP: begin
                if (tmr_done) begin
                    state_d  = S_RLOW;
                    tmr_load = 1'b1;
                    tmr_val  = TMR_W'(RE_LOW_CYC - 1);
                end
            end
            S_RLOW: begin
                if (tmr_done) begin
                    rbyte_d  = dq_i;
                    state_d  = S_RHIGH;
                    tmr_load = 1'b1;
                    tmr_val  = TMR_W'(RE_HIGH_CYC - 1);
                end
            end
            S_RHIGH: begin
                if (tmr_done) begin
                    state_d = S_IDLE;
                end
            end
            S_BGAP: begin
                if (tmr_done) begin
                    state_d  = S_BUSY;
                    tmr_load = 1'b1;
                    tmr_val  = lim_q;
                end
            end
            S_BUSY: begin
                if (rb_n) begin
                    state_d = S_IDLE;
                end else if (tmr_done) begin
                    tmo_d   = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (state_q != S_IDLE && wr_op) begin
            ref_d = 1'b1;
        end
        // Register read, answer next cycle
        if (req.rd) begin
            if (req.addr == REG_DATA) begin
                rdata_d = {24'h0, rbyte_q};
            end else if (req.addr == REG_CTRL) begin
                rdata_d = {{(32 - CTRL_W){1'b0}}, ctrl_q};
            end else if (req.addr == REG_STATUS) begin
                rdata_d[ST_ENG] = (state_q != S_IDLE);
                rdata_d[ST_DEV] = !rb_n;
                rdata_d[ST_TMO] = tmo_q;
                rdata_d[ST_REF] = ref_q;
                rdata_d[ST_TPP] = tpp_q;
                rdata_d[ST_TPE] = tpe_q;
                rdata_d[ST_CNT_LO +: 3] = cnt_q;
            end
        end
    end

    // Pin levels for the coming state
    always_comb begin
        pins_d.ce_n = !ctrl_d[CTRL_SEL];
        pins_d.cle  = (state_d == S_SETUP || state_d == S_WLOW
                       || state_d == S_WHIGH)
                      && kind_d == NCI_CYC_CMD;
        pins_d.ale  = (state_d == S_SETUP || state_d == S_WLOW
                       || state_d == S_WHIGH)
                      && kind_d == NCI_CYC_ADDR;
        pins_d.we_n = (state_d != S_WLOW);
        pins_d.re_n = (state_d != S_RLOW);
        pins_d.wp_n = ctrl_d[CTRL_GUARD];
    end

    // State registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            kind_q  <= NCI_CYC_CMD;
            byte_q  <= 8'h00;
            rbyte_q <= 8'h00;
            lim_q   <= '0;
            post_q  <= 1'b0;
            ctrl_q  <= CTRL_RESET;
            tmo_q   <= 1'b0;
            ref_q   <= 1'b0;
            tpp_q   <= 1'b0;
            tpe_q   <= 1'b0;
            key_q   <= 24'h000000;
            lkey_q  <= 24'h000000;
            pkey_q  <= 24'h000000;
            cnt_q   <= 3'h0;
            last_q  <= 8'h00;
            rdata_q <= 32'h00000000;
            pins_q  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                         re_n: 1'b1, wp_n: 1'b0};
            dq_oe   <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q  <= kind_d;
            byte_q  <= byte_d;
            rbyte_q <= rbyte_d;
            lim_q   <= lim_d;
            post_q  <= post_d;
            ctrl_q  <= ctrl_d;
            tmo_q   <= tmo_d;
            ref_q   <= ref_d;
            tpp_q   <= tpp_d;
            tpe_q   <= tpe_d;
            key_q   <= key_d;
            lkey_q  <= lkey_d;
            pkey_q  <= pkey_d;
            cnt_q   <= cnt_d;
            last_q  <= last_d;
            rdata_q <= rdata_d;
            pins_q  <= pins_d;
            dq_oe   <= (state_d == S_SETUP || state_d == S_WLOW
                        || state_d == S_WHIGH);
        end
    end

    assign pins  = pins_q;
    assign dq_o  = byte_q;
    assign rdata = rdata_q;

endmodule

// File: nci_pkg.sv
// Constants, codes and carriers for the flash host command engine
package nci_pkg;

    // Clock rate
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS  = 10;

    // Least time in ns to whole clock cycles, never below one
    function automatic int cdiv(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Pin timing in ns
    localparam int T_WP_NS  = 10;
    localparam int T_WH_NS  = 7;
    localparam int T_REA_NS = 16;
    localparam int T_REH_NS = 7;
    localparam int T_WHR_NS = 60;
    localparam int T_WB_NS  = 100;

    localparam int WE_LOW_CYC  = cdiv(T_WP_NS);
    localparam int WE_HIGH_CYC = cdiv(T_WH_NS);
    localparam int RE_LOW_CYC  = cdiv(T_REA_NS) + 1;
    localparam int RE_HIGH_CYC = cdiv(T_REH_NS);
    localparam int WHR_CYC     = cdiv(T_WHR_NS);
    localparam int WB_CYC      = cdiv(T_WB_NS);

    // Longest busy times, figures as printed
    localparam int ARRAY_FETCH_US     = 25;
    localparam int CACHE_FETCH_US     = 25;
    localparam int PLANE_SWITCH_US    = 1;
    localparam int OPTION_ACCESS_US   = 1;
    localparam int PAGE_WRITE_US      = 700;
    localparam int PAGE_WRITE_RAND_US = 740;
    localparam int CACHE_WRITE_US     = 700;
    localparam int BLOCK_CLEAR_MS     = 6;
    localparam int BLOCK_CLEAR2_MS    = 7;
    localparam int RESET_ERASE_US     = 500;

    localparam int ARRAY_FETCH_CYC   = ARRAY_FETCH_US * CLK_MHZ;
    localparam int CACHE_FETCH_CYC   = CACHE_FETCH_US * CLK_MHZ;
    localparam int PLANE_SWITCH_CYC  = PLANE_SWITCH_US * CLK_MHZ;
    localparam int OPTION_ACCESS_CYC = OPTION_ACCESS_US * CLK_MHZ;
    localparam int PAGE_WRITE_CYC    = PAGE_WRITE_US * CLK_MHZ;
    localparam int PAGE_WRITE_R_CYC  = PAGE_WRITE_RAND_US * CLK_MHZ;
    localparam int CACHE_WRITE_CYC   = CACHE_WRITE_US * CLK_MHZ;
    localparam int BLOCK_CLEAR_CYC   = BLOCK_CLEAR_MS * 1000 * CLK_MHZ;
    localparam int BLOCK_CLEAR2_CYC  = BLOCK_CLEAR2_MS * 1000 * CLK_MHZ;
    localparam int RESET_CYC         = RESET_ERASE_US * CLK_MHZ;

    // Partial write limits per page
    localparam logic [2:0] PARTIAL_WRITE_LIMIT      = 3'h4;
    localparam logic [2:0] PARTIAL_WRITE_LIMIT_SCRM = 3'h1;

    // Command codes
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_READ_CONF = 8'h30;
    localparam logic [7:0] CMD_RND_OUT   = 8'h05;
    localparam logic [7:0] CMD_RND_OUT_C = 8'he0;
    localparam logic [7:0] CMD_RND_IN    = 8'h85;
    localparam logic [7:0] CMD_CACHE_RD  = 8'h31;
    localparam logic [7:0] CMD_CACHE_END = 8'h3f;
    localparam logic [7:0] CMD_ID        = 8'h90;
    localparam logic [7:0] CMD_PARAM     = 8'hec;
    localparam logic [7:0] CMD_UID       = 8'hed;
    localparam logic [7:0] CMD_SET_FEAT  = 8'hef;
    localparam logic [7:0] CMD_GET_FEAT  = 8'hee;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    localparam logic [7:0] CMD_PROG      = 8'h80;
    localparam logic [7:0] CMD_PROG_P2   = 8'h81;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_CACHE_PRG = 8'h15;
    localparam logic [7:0] CMD_PLANE_PRG = 8'h11;
    localparam logic [7:0] CMD_ERASE     = 8'h60;
    localparam logic [7:0] CMD_ERASE_CNF = 8'hd0;
    localparam logic [7:0] CMD_PLANE_ERS = 8'hd1;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_STATUS_EN = 8'h78;
    localparam logic [7:0] CMD_PROT_STAT = 8'h7a;

    // Register offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_READ   = 8'h0c;
    localparam logic [7:0] REG_CTRL   = 8'h10;
    localparam logic [7:0] REG_WAIT   = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    // Control and status fields
    localparam int CTRL_SEL   = 0;
    localparam int CTRL_GUARD = 1;
    localparam int CTRL_SCRM  = 2;
    localparam int CTRL_W     = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam int ST_ENG     = 0;
    localparam int ST_DEV     = 1;
    localparam int ST_TMO     = 2;
    localparam int ST_REF     = 3;
    localparam int ST_TPP     = 4;
    localparam int ST_TPE     = 5;
    localparam int ST_CNT_LO  = 8;

    typedef enum logic [1:0] {NCI_CYC_CMD, NCI_CYC_ADDR, NCI_CYC_DATA}
        nci_kind_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } nci_req_s;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
    } nci_pins_s;

endpackage

// File: nci_timer.sv
// Down counter that times strobe phases and busy limits
`timescale 1ns/1ps
module nci_timer #(
    parameter int W = 20
) (
    input  wire logic         clk,      // System clock
    input  wire logic         sys_rst,  // Async reset, high
    input  wire logic         load,     // Load pulse
    input  wire logic [W-1:0] load_val, // Cycles left after load
    output logic              done      // Count reached zero
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Next count
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Count register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);

endmodule

// File: nci_host_monitor.sv
// Pin sequencing checker for the flash host
`timescale 1ns/1ps
module nci_host_monitor
    import nci_pkg::*;
(
    input wire logic               clk,     // Clock
    input wire logic               sys_rst, // Reset
    input wire nci_pkg::nci_req_s  req,     // Request
    input wire logic [31:0]        rdata,   // Read data
    input wire nci_pkg::nci_pins_s pins,    // Pins
    input wire logic [7:0]         dq_o,    // Bus out
    input wire logic               dq_oe,   // Bus enable
    input wire logic [7:0]         dq_i,    // Bus in
    input wire logic               rb_n     // Ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Strobe and latch relations
    a_latch_excl: assert property (pins.cle |-> !pins.ale)
        else $error("both latches high");
    a_addr_qual: assert property (pins.ale |-> !pins.cle && pins.re_n)
        else $error("address latch badly qualified");
    a_we_pulse: assert property ($fell(pins.we_n) |->
        !pins.ce_n && pins.re_n ##1 pins.we_n[*2]) else $error("bad strobe");
    a_data_setup: assert property ($fell(pins.we_n) |->
        dq_oe && $stable(dq_o)) else $error("bus not set up");
    a_latch_hold: assert property ($rose(pins.we_n) |-> dq_oe &&
        $stable({pins.cle, pins.ale, dq_o})) else $error("no hold");
    a_guard_data: assert property ($fell(pins.we_n) && !pins.cle &&
        !pins.ale |-> pins.wp_n) else $error("data with guard low");
    a_read_span: assert property ($fell(pins.re_n) |-> !dq_oe &&
        pins.we_n ##0 !pins.re_n[*3] ##1 pins.re_n) else $error("bad read");
    a_ce_quiet: assert property (pins.ce_n |->
        pins.we_n && pins.re_n && !dq_oe) else $error("strobe while idle");
    c_cmd: cover property ($fell(pins.we_n) && pins.cle);
    c_addr: cover property ($fell(pins.we_n) && pins.ale);
    c_read: cover property ($fell(pins.re_n));
endmodule

// File: nci_flash_model.sv
// Behavioural flash device facing the host
`timescale 1ns/1ps
module nci_flash_model
    import nci_pkg::*;
#(
    parameter int BUSY_CYC = 40
) (
    input  wire logic               clk,   // Clock
    input  wire nci_pkg::nci_pins_s pins,  // Pins
    input  wire logic [7:0]         dq_o,  // Host bus
    input  wire logic               dq_oe, // Host enable
    input  wire logic               hold_busy, // Keeps the flag low
    output logic [7:0]              dq_i,  // Device bus
    output logic                    rb_n   // Ready flag
);
    logic [7:0] adr_q;
    int         left;
    initial begin
        adr_q = 8'h00;
        left = 0;
        rb_n = 1'b1;
    end
    // Latch bytes on the rising input strobe while selected
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.re_n && pins.cle && !pins.ale) begin
            if ((left == 0 || dq_o == 8'hff) && dq_o inside {8'h30, 8'h31,
                8'h3f, 8'h10, 8'h15, 8'h11, 8'hd1, 8'hd0, 8'hff}) begin
                left = BUSY_CYC;
            end
        end
        if (!pins.ce_n && pins.ale && !pins.cle) adr_q = dq_o;
    end
    // Busy count and pulled-up ready flag
    always @(posedge clk) begin
        if (left > 0) left = left - 1;
        rb_n <= (left == 0) && !hold_busy;
    end
    // Write guard falling aborts a program or erase in progress
    always @(negedge pins.wp_n) left = 0;
    // Bus released shows inverse when not read
    assign dq_i = (!pins.ce_n && !pins.re_n) ? adr_q : ~adr_q;
endmodule

// File: tb_top.sv
// Self-checking bench for the flash host engine
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import nci_pkg::*;
    logic        clk, sys_rst, dq_oe, rb_n, hold_busy;
    logic [31:0] rdata;
    logic [7:0]  dq_o, dq_i;
    nci_req_s    req;
    nci_pins_s   pins;
    int          fail_count = 0, compares = 0, cyc = 0;
    logic [7:0]  codes [26] = '{8'h90, 8'hec, 8'hed, 8'hef, 8'hee, 8'h78,
        8'h7a, 8'h00, 8'h30, 8'h31, 8'h3f, 8'h05, 8'he0, 8'h85, 8'h80, 8'h11,
        8'h81, 8'h15, 8'h80, 8'h10, 8'h60, 8'hd1, 8'h60, 8'hd0, 8'hff, 8'h70};
    nci_host #(.PROG_CYC(200), .PROGR_CYC(220), .CACHE_CYC(200),
        .ERASE_CYC(300), .ERS2_CYC(350)) u_nci_host (
        .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .pins(pins),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .rb_n(rb_n));
    nci_flash_model u_nci_flash_model (.clk(clk), .pins(pins), .dq_o(dq_o),
        .dq_oe(dq_oe), .hold_busy(hold_busy), .dq_i(dq_i), .rb_n(rb_n));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d & m, e)
    endtask
    // Byte request, then poll until the engine is idle
    task automatic wrb(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        wr(a, v);
        d = 32'h1;
        for (int i = 0; i < 500 && d[0] !== 1'b0; i++) rd(REG_STATUS, d);
        `CHK(d[0], 1'b0)
    endtask
    task give_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        sys_rst = 1'b1;
        req = '0;
        hold_busy = 1'b0;
        repeat (12) @(posedge clk);
        `CHK(pins, 6'h26)
        sys_rst <= 1'b0;
        chk(REG_CTRL, 32'h7, 32'h0);
        chk(8'h40, 32'hffffffff, 32'h0);
        wr(REG_CMD, 32'h90);
        chk(REG_STATUS, 32'h8, 32'h8);
        wr(REG_STATUS, 32'h8);
        wr(REG_CTRL, 32'h1);
        wr(REG_CMD, 32'h80);
        chk(REG_STATUS, 32'h8, 32'h8);
        wr(REG_STATUS, 32'h8);
        wr(REG_CTRL, 32'h3);
        wr(REG_CMD, 32'h23);
        chk(REG_STATUS, 32'h8, 32'h8);
        wr(REG_STATUS, 32'h8);
        foreach (codes[i]) begin
            wrb(REG_CMD, {24'h0, codes[i]});
            chk(REG_STATUS, 32'hc, 32'h0);
        end
        // Flash held busy: status codes pass, protection status refused
        @(posedge clk);
        hold_busy <= 1'b1;
        repeat (3) @(posedge clk);
        wr(REG_CMD, 32'h7a);
        chk(REG_STATUS, 32'ha, 32'ha);
        wr(REG_STATUS, 32'h8);
        wrb(REG_CMD, 32'h70);
        wrb(REG_CMD, 32'h78);
        chk(REG_STATUS, 32'ha, 32'h2);
        @(posedge clk);
        hold_busy <= 1'b0;
        repeat (2) @(posedge clk);
        wrb(REG_DATA, 32'h3c);
        wrb(REG_CMD, 32'h90);
        wrb(REG_ADDR, 32'h5a);
        wrb(REG_READ, 32'h0);
        chk(REG_DATA, 32'hff, 32'h5a);
        give_verdict();
    end
endmodule
bind nci_host nci_host_monitor u_nci_host_monitor (.clk(clk),
    .sys_rst(sys_rst), .req(req), .rdata(rdata), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .rb_n(rb_n));
